// ### shared/qadc_map.vh
// qadc_map.vh: constants of the quad converter frame control
// assumes inclusion by bare name from the frame control design file
`ifndef QADC_MAP_VH
`define QADC_MAP_VH

// conversion group layout, counted in serial-clock cycles
`define QADC_GROUP_LEN 5'd16
`define QADC_TRACK_CYCLES 4'd3
`define QADC_HOLD_FALL 4'd4
`define QADC_CTRL_BITS 4'd8
`define QADC_LAST_RISE 4'd15

// control word field positions
`define QADC_CTRL_WIDTH 8
`define QADC_ADDR_MSB 5
`define QADC_ADDR_LSB 3
`define QADC_SEL_MSB 4
`define QADC_SEL_LSB 3
`define QADC_CTRL_RESET 8'h00

// channel codes; power-up selects the first input
`define QADC_CH_ONE 2'h0
`define QADC_CH_TWO 2'h1
`define QADC_CH_THREE 2'h2
`define QADC_CH_FOUR 2'h3
`define QADC_CH_RESET 2'h0

// result word
`define QADC_RESULT_BITS 12
`define QADC_RESULT_RESET 12'h000

// sequencer states
`define QADC_ST_IDLE 3'h0
`define QADC_ST_WAIT 3'h1
`define QADC_ST_TRACK 3'h2
`define QADC_ST_HOLD 3'h3
`define QADC_ST_GAP 3'h4

`endif

// ### rtl/qadc_sync.v
// qadc_sync.v: two-flop synchroniser for a bundle of pin levels
// assumes each bit is an unrelated level; reset value is a constant
`default_nettype none

module qadc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // pin side
    input wire [WIDTH-1:0] asyncIn,
    // clock side
    output wire [WIDTH-1:0] syncOut
);

reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] stable_q;

always @(posedge clk)
begin
    if (!reset_n)
    begin
        meta_q <= RESET_VAL;
        stable_q <= RESET_VAL;
    end
    else
    begin
        meta_q <= asyncIn;
        stable_q <= meta_q;
    end
end

assign syncOut = stable_q;

endmodule // qadc_sync

`default_nettype wire

// ### rtl/qadc_buf.v
// qadc_buf.v: two-entry valid/ready buffer for result words
// assumes source and sink share clk; storage in flip-flops
`default_nettype none

module qadc_buf #(
    parameter WIDTH = 12
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // filling side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // draining side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);

reg [WIDTH-1:0] entry_q [0:1];
reg wrPtr_q;
reg rdPtr_q;
reg [1:0] count_q;
wire doWrite;
wire doRead;

assign inReady = (count_q != 2'h2);
assign outValid = (count_q != 2'h0);
assign outData = entry_q[rdPtr_q];
assign doWrite = inValid && inReady;
assign doRead = outValid && outReady;

genvar i;
generate
    for (i = 0; i < 2; i = i + 1)
    begin : gEntry
        always @(posedge clk)
        begin
            if (!reset_n)
                entry_q[i] <= {WIDTH{1'b0}};
            else if (doWrite && (wrPtr_q == i))
                entry_q[i] <= inData;
        end
    end
endgenerate

always @(posedge clk)
begin
    if (!reset_n)
    begin
        wrPtr_q <= 1'b0;
        rdPtr_q <= 1'b0;
        count_q <= 2'h0;
    end
    else
    begin
        if (doWrite)
            wrPtr_q <= ~wrPtr_q;
        if (doRead)
            rdPtr_q <= ~rdPtr_q;
        if (doWrite && !doRead)
            count_q <= count_q + 2'h1;
        else if (doRead && !doWrite)
            count_q <= count_q - 2'h1;
    end
end

endmodule // qadc_buf

`default_nettype wire

// ### rtl/qadc_frame_ctrl.v
// qadc_frame_ctrl.v: serial frame and conversion sequencing of a
// four-channel 12-bit converter, seen from inside the device.
// assumes the serial pins are asynchronous to clk and slow enough
// (several clk periods per serial half-cycle) to be oversampled.
//
// Notes on behaviour
// - frame opens on select fall, closes on rise
// - track input during first three cycles
// - hold and convert during cycles four to sixteen
// - result leaves MSB first from fifth cycle
// - retrack after sixteenth rise, hold at fourth fall
// - data out driven only while select low
// - power down outside frame and between conversions
// - clock gated; select fall counts as fall
// - clock idling high: track on first real fall
// - first eight rising edges capture control word
// - only bits five to three address channel
// - low two address bits pick one input
// - first conversion after power-up uses input one
// - close edges may delay capture by one
// - result is plain straight binary code
// - conversions repeat while select stays low
`default_nettype none
`include "qadc_map.vh"

module qadc_frame_ctrl #(
    parameter RESULT_BITS = `QADC_RESULT_BITS
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // serial pins
    input wire frameSelectN,
    input wire serialClk,
    input wire serialDataIn,
    output reg serialDataOut,
    output wire serialDataOutEn,
    // converter core control
    output reg [1:0] chanSel,
    output wire trackMode,
    output wire powerDown,
    output reg convStart,
    // converter core result
    input wire [RESULT_BITS-1:0] convResult,
    input wire convResultValid,
    output wire convResultReady,
    // status
    output reg [`QADC_CTRL_WIDTH-1:0] ctrlWord,
    output reg resultMissed
);

// synchronised pin levels
wire frameSelNSync;
wire serialClkSync;
wire serialDataInSync;

// edge detection on the oversampled serial clock
reg serialClkPrev_q;
reg frameSelPrev_q;
wire clkRise;
wire clkFall;
wire frameFall;
wire frameRise;

// sequencer
reg [2:0] state_q;
reg [2:0] state_d;
reg [3:0] fallIdx_q;
reg [3:0] fallIdx_d;
reg [3:0] riseIdx_q;
reg [3:0] riseIdx_d;
reg groupStart;
reg holdEntry;
reg shiftStep;

// control word reception
reg [`QADC_CTRL_WIDTH-2:0] ctrlShift_q;
reg [1:0] pendingChan_q;
wire [`QADC_CTRL_WIDTH-1:0] ctrlNext;
wire captureBit;
wire captureLast;

// result shifter
reg [RESULT_BITS-1:0] outShift_q;
wire bufValid;
wire bufReady;
wire [RESULT_BITS-1:0] bufData;

// all three pins sampled with equal depth so data stays aligned
// with the clock edges that qualify it
qadc_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
) uPinSync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn({frameSelectN, serialClk, serialDataIn}),
    .syncOut({frameSelNSync, serialClkSync, serialDataInSync})
);

// results from the core wait here until the fourth fall of a group;
// a slow frame stalls the core instead of dropping a word
qadc_buf #(
    .WIDTH(RESULT_BITS)
) uResultBuf (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(convResultValid),
    .inReady(convResultReady),
    .inData(convResult),
    .outValid(bufValid),
    .outReady(bufReady),
    .outData(bufData)
);

always @(posedge clk)
begin
    if (!reset_n)
    begin
        serialClkPrev_q <= 1'b0;
        frameSelPrev_q <= 1'b1;
    end
    else
    begin
        serialClkPrev_q <= serialClkSync;
        frameSelPrev_q <= frameSelNSync;
    end
end

// edges only count while the frame is open
assign frameFall = frameSelPrev_q && !frameSelNSync;
assign frameRise = !frameSelPrev_q && frameSelNSync;
assign clkRise = !frameSelNSync && serialClkSync && !serialClkPrev_q;
assign clkFall = !frameSelNSync && !serialClkSync && serialClkPrev_q;

// serial data pin is driven for exactly the open frame
assign serialDataOutEn = !frameSelNSync;

assign trackMode = (state_q == `QADC_ST_TRACK);
// idle and the gap after the sixteenth rise are low-power
assign powerDown = (state_q == `QADC_ST_IDLE) ||
    (state_q == `QADC_ST_WAIT) || (state_q == `QADC_ST_GAP);

// a word popped at hold entry is the result shifted out this group
assign bufReady = holdEntry;

// control word bits, MSB first, on rises zero to seven of a group
assign captureBit = clkRise && (riseIdx_q < `QADC_CTRL_BITS) &&
    ((state_q == `QADC_ST_TRACK) || (state_q == `QADC_ST_HOLD));
assign captureLast = captureBit &&
    (riseIdx_q == (`QADC_CTRL_BITS - 4'd1));
assign ctrlNext = {ctrlShift_q, serialDataInSync};

always @*
begin
    state_d = state_q;
    fallIdx_d = fallIdx_q;
    riseIdx_d = riseIdx_q;
    groupStart = 1'b0;
    holdEntry = 1'b0;
    shiftStep = 1'b0;
    case (state_q)
        `QADC_ST_IDLE:
        begin
            if (frameFall)
            begin
                riseIdx_d = 4'h0;
                if (!serialClkSync)
                begin
                    // clock idling low: the select fall is the first fall
                    state_d = `QADC_ST_TRACK;
                    fallIdx_d = 4'h1;
                    groupStart = 1'b1;
                end
                else
                begin
                    state_d = `QADC_ST_WAIT;
                    fallIdx_d = 4'h0;
                end
            end
        end
        `QADC_ST_WAIT:
        begin
            if (clkFall)
            begin
                state_d = `QADC_ST_TRACK;
                fallIdx_d = 4'h1;
                groupStart = 1'b1;
            end
        end
        `QADC_ST_TRACK:
        begin
            if (clkRise)
                riseIdx_d = riseIdx_q + 4'h1;
            if (clkFall)
            begin
                fallIdx_d = fallIdx_q + 4'h1;
                if (fallIdx_q == `QADC_TRACK_CYCLES)
                begin
                    // fourth fall ends tracking after three cycles
                    state_d = `QADC_ST_HOLD;
                    holdEntry = 1'b1;
                end
            end
        end
        `QADC_ST_HOLD:
        begin
            if (clkFall)
            begin
                fallIdx_d = fallIdx_q + 4'h1;
                shiftStep = 1'b1;
            end
            if (clkRise)
            begin
                if (riseIdx_q == `QADC_LAST_RISE)
                begin
                    state_d = `QADC_ST_GAP;
                    riseIdx_d = 4'h0;
                end
                else
                    riseIdx_d = riseIdx_q + 4'h1;
            end
        end
        `QADC_ST_GAP:
        begin
            // next fall starts another conversion without end
            if (clkFall)
            begin
                state_d = `QADC_ST_TRACK;
                fallIdx_d = 4'h1;
                groupStart = 1'b1;
            end
        end
        default:
        begin
            state_d = `QADC_ST_IDLE;
        end
    endcase
    // closing the frame aborts any group in flight
    if (frameRise || frameSelNSync)
    begin
        state_d = `QADC_ST_IDLE;
        fallIdx_d = 4'h0;
        riseIdx_d = 4'h0;
        groupStart = 1'b0;
        holdEntry = 1'b0;
        shiftStep = 1'b0;
    end
end

always @(posedge clk)
begin
    if (!reset_n)
    begin
        state_q <= `QADC_ST_IDLE;
        fallIdx_q <= 4'h0;
        riseIdx_q <= 4'h0;
    end
    else
    begin
        state_q <= state_d;
        fallIdx_q <= fallIdx_d;
        riseIdx_q <= riseIdx_d;
    end
end

// control word: shift, then latch the full word on the eighth rise.
// the channel field waits in pendingChan until the next group, so
// the word never disturbs the conversion already being tracked
always @(posedge clk)
begin
    if (!reset_n)
    begin
        ctrlShift_q <= 7'h00;
        ctrlWord <= `QADC_CTRL_RESET;
        pendingChan_q <= `QADC_CH_RESET;
    end
    else
    begin
        if (frameFall)
            ctrlShift_q <= 7'h00;
        else if (captureBit)
            ctrlShift_q <= ctrlNext[`QADC_CTRL_WIDTH-2:0];
        if (captureLast)
        begin
            ctrlWord <= ctrlNext;
            // bits 7, 6, 5 and 2..0 are dropped here
            pendingChan_q <= ctrlNext[`QADC_SEL_MSB:`QADC_SEL_LSB];
        end
    end
end

// 00..11 map straight onto inputs one to four; address bit 2 unused
always @(posedge clk)
begin
    if (!reset_n)
        chanSel <= `QADC_CH_RESET;
    else if (groupStart)
        chanSel <= pendingChan_q;
end

// conversion start pulse to the core at the moment of hold
always @(posedge clk)
begin
    if (!reset_n)
    begin
        convStart <= 1'b0;
        resultMissed <= 1'b0;
    end
    else
    begin
        convStart <= holdEntry;
        // core had nothing ready: zeros go out and this flags it
        resultMissed <= holdEntry && !bufValid;
    end
end

// output bit changes only after falls so the host samples on rises.
// falls 1..4 leave zero, falls 5..16 carry the MSB down to the LSB
always @(posedge clk)
begin
    if (!reset_n)
    begin
        serialDataOut <= 1'b0;
        outShift_q <= `QADC_RESULT_RESET;
    end
    else if (frameSelNSync || groupStart)
    begin
        serialDataOut <= 1'b0;
        outShift_q <= `QADC_RESULT_RESET;
    end
    else if (holdEntry)
    begin
        // fourth zero goes out now; the MSB waits for the fifth fall
        // so the host finds four zeros ahead of the result
        serialDataOut <= 1'b0;
        if (bufValid)
        begin
            // straight binary code passes through unaltered
            outShift_q <= bufData;
        end
        else
        begin
            outShift_q <= `QADC_RESULT_RESET;
        end
    end
    else if (shiftStep)
    begin
        // zeros shift in behind the result
        serialDataOut <= outShift_q[RESULT_BITS-1];
        outShift_q <= {outShift_q[RESULT_BITS-2:0], 1'b0};
    end
end

// a select fall landing right beside a clock fall can be seen in the
// same or an adjacent sample; the pin sync shows either order, which
// at worst shifts capture by one serial clock, as tolerated

endmodule // qadc_frame_ctrl

`default_nettype wire

// ### verification/qadc_frame_ctrl_chk.sv
// qadc_frame_ctrl_chk.sv: port-level assertions for the frame control
// assumes bind onto qadc_frame_ctrl; pins change slowly against clk
`default_nettype none

module qadc_frame_ctrl_chk #(
    parameter int RESULT_BITS = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // serial pins
    input wire logic frameSelectN,
    input wire logic serialClk,
    input wire logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOutEn,
    // converter core side
    input wire logic [1:0] chanSel,
    input wire logic trackMode,
    input wire logic powerDown,
    input wire logic convStart,
    input wire logic [RESULT_BITS-1:0] convResult,
    input wire logic convResultValid,
    input wire logic convResultReady,
    // status
    input wire logic [7:0] ctrlWord,
    input wire logic resultMissed
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence holdEntry;
        $fell(trackMode) && !powerDown;
    endsequence
    // synced clock level is two edges behind the pin
    sequence lowIdleOpen;
        $rose(serialDataOutEn) && !$past(serialClk, 2);
    endsequence

    oe_follows_sel_a: assert property (
        serialDataOutEn == !$past(frameSelectN, 2))
        else $error("output enable does not follow select");
    idle_power_down_a: assert property (frameSelectN [*4] |-> powerDown)
        else $error("awake outside a frame");
    track_from_pd_a: assert property ($rose(trackMode) |-> $past(powerDown))
        else $error("track entered without prior power down");
    track_min_len_a: assert property ($rose(trackMode) |-> trackMode [*8])
        else $error("track phase cut short");
    // convStart is registered, so it rises in the cycle trackMode falls
    hold_start_a: assert property (holdEntry |-> convStart)
        else $error("no conversion start at hold entry");
    start_pulse_a: assert property (convStart |=> !convStart)
        else $error("conversion start longer than one cycle");
    low_idle_track_a: assert property (lowIdleOpen |=> trackMode)
        else $error("select fall did not start tracking");
    high_idle_wait_a: assert property (
        $rose(serialDataOutEn) && $past(serialClk, 2)
        |=> powerDown && !trackMode)
        else $error("tracking before first real clock fall");
    ctrl_in_hold_a: assert property (
        $changed(ctrlWord) |-> !trackMode && !powerDown)
        else $error("control word updated outside conversion");
    chan_at_track_a: assert property ($changed(chanSel) |-> trackMode)
        else $error("channel changed outside track");
    miss_flag_a: assert property (resultMissed |-> convStart)
        else $error("missed result flagged outside hold entry");
    idle_out_low_a: assert property (
        !serialDataOutEn [*2] |-> !serialDataOut)
        else $error("data out not cleared outside a frame");
endmodule // qadc_frame_ctrl_chk

bind qadc_frame_ctrl qadc_frame_ctrl_chk #(.RESULT_BITS(RESULT_BITS)) chk (
    .clk(clk), .reset_n(reset_n), .frameSelectN(frameSelectN),
    .serialClk(serialClk), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
    .chanSel(chanSel), .trackMode(trackMode), .powerDown(powerDown),
    .convStart(convStart), .convResult(convResult),
    .convResultValid(convResultValid), .convResultReady(convResultReady),
    .ctrlWord(ctrlWord), .resultMissed(resultMissed)
);

`default_nettype wire

// ### verification/qadc_host_model.sv
// qadc_host_model.sv: behavioural serial host for the frame control
// assumes the bench calls its tasks; link period is twice HALF
`default_nettype none

module qadc_host_model #(
    parameter int HALF = 100
) (
    // serial pins
    output logic frameSelectN,
    output logic serialClk,
    output logic serialDataIn,
    input wire logic serialDataOut,
    // received word
    output logic [15:0] rxWord,
    output logic rxDone
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        frameSelectN = 1'b1;
        serialClk = 1'b0;
        serialDataIn = 1'b0;
        rxWord = 16'h0000;
        rxDone = 1'b0;
    end

    // clock stands still between frames; odd offset keeps phase apart
    task automatic openFrame(input logic idleHigh);
        serialClk = idleHigh;
        #(2 * HALF + 7) frameSelectN = 1'b0;
        if (idleHigh)
            #HALF serialClk = 1'b0;
    endtask

    task automatic group(input logic [7:0] word, input int rises);
        for (int i = 0; i < rises; i++)
        begin
            serialDataIn = (i < 8) ? word[7 - i] : ~serialDataIn;
            #HALF serialClk = 1'b1;
            rxWord = {rxWord[14:0], serialDataOut};
            #HALF serialClk = 1'b0;
        end
        rxDone = (rises == 16);
        #1 rxDone = 1'b0;
    endtask

    task automatic closeFrame();
        #(3 * HALF) frameSelectN = 1'b1;
        serialDataIn = ~serialDataIn;
    endtask
endmodule // qadc_host_model

`default_nettype wire

// ### verification/qadc_frame_ctrl_tb.sv
// qadc_frame_ctrl_tb.sv: self-checking bench for qadc_frame_ctrl
// assumes the host model drives the pins and this bench the core side
`default_nettype none

module qadc_frame_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic convResultValid = 1'b0;
    logic [11:0] convResult = 12'h000;
    wire frameSelectN, serialClk, serialDataIn, serialDataOut;
    wire serialDataOutEn, trackMode, powerDown, convStart;
    wire convResultReady, resultMissed, rxDone;
    wire [1:0] chanSel;
    wire [7:0] ctrlWord;
    wire [15:0] rxWord;
    // no pull on the data pin: out of frame the host sees z
    wire doutPin = serialDataOutEn ? serialDataOut : 1'bz;
    logic [11:0] coreQ[$];
    logic [11:0] res[$];
    logic [25:0] noteQ[$];
    logic [1:0] pend;
    logic [7:0] lastWord;
    int failures = 0;
    int totalChecks = 0;
    int cycles = 0;
    int misses = 0;

    always #12.5 clk = ~clk;

    qadc_frame_ctrl #(.RESULT_BITS(12)) dut (
        .clk(clk), .reset_n(reset_n), .frameSelectN(frameSelectN),
        .serialClk(serialClk), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
        .chanSel(chanSel), .trackMode(trackMode), .powerDown(powerDown),
        .convStart(convStart), .convResult(convResult),
        .convResultValid(convResultValid),
        .convResultReady(convResultReady),
        .ctrlWord(ctrlWord), .resultMissed(resultMissed)
    );

    qadc_host_model #(.HALF(100)) host (
        .frameSelectN(frameSelectN), .serialClk(serialClk),
        .serialDataIn(serialDataIn), .serialDataOut(doutPin),
        .rxWord(rxWord), .rxDone(rxDone)
    );

    task automatic end_of_test();
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [25:0] got, input logic [25:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // core side: word offered until the buffer takes it
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (convResultValid && convResultReady)
            void'(coreQ.pop_front());
        if (resultMissed)
            misses <= misses + 1;
        if (cycles == 8000)
        begin
            failures++;
            end_of_test();
        end
    end

    always @(negedge clk)
    begin
        convResultValid <= (coreQ.size() != 0);
        convResult <= (coreQ.size() != 0) ? coreQ[0] : 12'h000;
    end

    always @(posedge rxDone)
    begin
        if (noteQ.size() != 0)
            check({ctrlWord, chanSel, rxWord}, noteQ.pop_front());
    end

    task automatic runGroup(input int k);
        logic [7:0] w;
        w = 8'($urandom());
        w[4:3] = 2'(k);
        noteQ.push_back({w, pend, 4'h0, res[k]});
        pend = w[4:3];
        lastWord = w;
        host.group(w, 16);
    endtask

    initial
    begin
        void'($urandom(4582));
        pend = 2'h0;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        check({ctrlWord, serialDataOutEn, powerDown}, {8'h00, 2'b01});
        for (int i = 0; i < 8; i++)
            coreQ.push_back(12'($urandom()));
        res = coreQ;
        repeat (8) @(negedge clk);
        check(convResultReady, 1'b0);
        host.openFrame(1'b0);
        for (int k = 0; k < 5; k++)
            runGroup(k);
        host.closeFrame();
        host.openFrame(1'b1);
        for (int k = 5; k < 8; k++)
            runGroup(k);
        host.closeFrame();
        host.openFrame(1'b0);
        host.group(8'hff, 2);
        host.closeFrame();
        // core queue is empty now: zeros go out and the miss is flagged
        res.push_back(12'h000);
        host.openFrame(1'b0);
        runGroup(8);
        host.closeFrame();
        repeat (8) @(negedge clk);
        check(26'(misses), 26'h1);
        check({ctrlWord, powerDown, serialDataOutEn}, {lastWord, 2'b10});
        check(noteQ.size(), 26'h0);
        end_of_test();
    end
endmodule // qadc_frame_ctrl_tb

`default_nettype wire
